// ===== common/flash_pkg.sv
// Constants, command codes and operation states for the serial flash slave.
// Assumes a 10 MHz system clock; the serial clock is a separate domain.
package flash_pkg;
  // Command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_PDOWN = 8'hB9;
  localparam logic [7:0] CMD_ID = 8'hAB;
  localparam logic [7:0] CMD_SSE_A = 8'h20;
  localparam logic [7:0] CMD_SSE_B = 8'hD7;
  localparam logic [7:0] CMD_SE = 8'hD8;
  localparam logic [7:0] CMD_CE_A = 8'h60;
  localparam logic [7:0] CMD_CE_B = 8'hC7;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SRW = 8'h01;
  // Frame lengths in bytes, byte counter width and last bit index
  localparam int BYTE_CNT_W = 10;
  localparam logic [BYTE_CNT_W-1:0] ONE_BYTE = 10'h001;
  localparam logic [BYTE_CNT_W-1:0] ADDR_FRAME_BYTES = 10'h004;
  localparam logic [BYTE_CNT_W-1:0] PP_MIN_BYTES = 10'h005;
  localparam logic [BYTE_CNT_W-1:0] SRW_FRAME_BYTES = 10'h002;
  localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_MAX = 10'h3FF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int POWER_UP_WAIT_TIME_US = 500;
  localparam int POWER_UP_WAIT_CYCLES =
    (POWER_UP_WAIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = 2000;
  localparam int PROG_CYCLES_DEF = 200;
  localparam int SRW_CYCLES_DEF = 100;
  // Values after reset
  localparam logic RST_WEN = 1'b0;
  localparam logic RST_PD = 1'b0;
  // Internal operation in progress
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_SRW = 2'b01,
    OP_PROG = 2'b11,
    OP_ERASE = 2'b10
  } op_t;
endpackage

// ===== src/serial_flash_hold_protect.sv
// Serial flash slave: hold, power-up standby, write framing checks,
// write-enable latch and short identification read.
// Assumes sck idles while cs_b is high; hold_b and si are synchronous to sck.
`timescale 1ns/1ps
module serial_flash_hold_protect #(
  parameter int unsigned PU_CYCLES = flash_pkg::POWER_UP_WAIT_CYCLES,
  parameter int unsigned ERASE_CYCLES = flash_pkg::ERASE_CYCLES_DEF,
  parameter int unsigned PROG_CYCLES = flash_pkg::PROG_CYCLES_DEF,
  parameter int unsigned SRW_CYCLES = flash_pkg::SRW_CYCLES_DEF,
  // Arbitrary value, not a real part code
  parameter logic [7:0] DEVICE_CODE = 8'hA5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  output logic so,
  output logic so_oe,
  output logic write_enabled,
  output logic busy,
  output logic powered_down,
  output logic pu_ready,
  output logic op_start,
  output logic op_done,
  output flash_pkg::op_t op_kind
);
  import flash_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  logic frame_rst_b;
  logic frame_q;
  logic tog_q;
  logic [2:0] bits_q;
  logic [BYTE_CNT_W-1:0] bytes_q;
  logic [7:0] shift_q;
  logic [7:0] cmd_q;
  logic out_en_q;
  logic so_q;
  logic hold_act;

  // Chip select high clears frame state, hold with it
  assign frame_rst_b = rst_b & ~cs_b;
  // Hold only matters inside a frame; host keeps its edges off sck high
  assign hold_act = ~cs_b & ~hold_b;

  // Frame started flag, set by the first sampled edge
  // Gated by hold, so noise edges in a pause never open a frame
  always_ff @(posedge sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      frame_q <= 1'b0;
    end else if (!hold_act) begin
      frame_q <= 1'b1;
    end
  end

  // Toggle tells the system side a real frame happened
  // One bit crosses instead of the counters; it flips once per frame
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      tog_q <= 1'b0;
    end else if (!hold_act && !cs_b && !frame_q) begin
      tog_q <= ~tog_q;
    end
  end

  // Bit and byte counters, shift register, command byte
  // Not cleared by cs_b so the system side can read them after the frame
  // Hold freezes all four, so the frame resumes at the same bit
  // The first edge of a frame reloads all but cmd_q; bytes_q back at zero keeps a cut frame from decoding
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      bits_q <= 3'h0;
      bytes_q <= '0;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
    end else if (!cs_b && !hold_act) begin
      if (!frame_q) begin
        bits_q <= 3'h1;
        bytes_q <= '0;
        shift_q <= {7'h00, si};
      end else begin
        bits_q <= bits_q + 3'h1;
        shift_q <= {shift_q[6:0], si};
        if (bits_q == LAST_BIT) begin
          if (bytes_q != BYTE_CNT_MAX) begin
            bytes_q <= bytes_q + ONE_BYTE;
          end
          if (bytes_q == '0) begin
            cmd_q <= {shift_q[6:0], si};
          end
        end
      end
    end
  end

  // Device code shifted out on falling edges, MSB first, repeating
  // Bit index comes from the bit counter, so a pause holds the pattern
  // Limitation: the code is driven even while powered down or busy
  always_ff @(negedge sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      out_en_q <= 1'b0;
      so_q <= 1'b0;
    end else if (!hold_act && frame_q && cmd_q == CMD_ID
                 && bytes_q >= ADDR_FRAME_BYTES) begin
      out_en_q <= 1'b1;
      so_q <= DEVICE_CODE[~bits_q];
    end
  end

  assign so = so_q;
  // Released at once on hold or deselect, no clock needed
  assign so_oe = out_en_q & ~cs_b & hold_b;

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: frame end detection

  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic seen_q;
  logic frame_end;
  logic new_frame;

  // Two-flop synchronisers for chip select and frame toggle
  // Third chip select stage only feeds the rising edge detector
  // Reset values match the idle pins, so no false edge after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_b;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
    end
  end

  assign frame_end = cs_s2_q & ~cs_s3_q;
  assign new_frame = frame_end & (tog_s2_q != seen_q);

  // Frames with no clock edges leave the toggle alone and are skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else if (frame_end) begin
      seen_q <= tog_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at frame end
  // Counters are quasi-static here: sck is idle once cs_b is high
  // Hazard: a new frame within three clk cycles of the last would race the decode
  // Every command but the identification wake must end on a byte boundary, not only the write types

  logic pu_ready_q;
  logic busy_q;
  logic wen_q;
  logic pd_q;
  logic aligned;
  logic gate;
  logic acc_wren;
  logic acc_wrdi;
  logic acc_pd;
  logic acc_exit;
  logic is_erase;
  logic start_erase;
  logic start_prog;
  logic start_srw;
  logic op_end;
  logic [31:0] op_cnt_q;

  assign aligned = (bits_q == 3'h0);
  // No command while powering up or busy; standby otherwise
  assign gate = new_frame & aligned & pu_ready_q & ~busy_q & ~pd_q;
  assign acc_wren = gate & (cmd_q == CMD_WREN) & (bytes_q == ONE_BYTE);
  assign acc_wrdi = gate & (cmd_q == CMD_WRDI) & (bytes_q == ONE_BYTE);
  assign acc_pd = gate & (cmd_q == CMD_PDOWN) & (bytes_q == ONE_BYTE);
  // A whole first identification byte wakes from power-down, on a byte boundary or not
  assign acc_exit = new_frame & pd_q & ~busy_q & (cmd_q == CMD_ID) & (bytes_q != '0);
  assign is_erase = (((cmd_q == CMD_SSE_A) || (cmd_q == CMD_SSE_B) || (cmd_q == CMD_SE))
                     && bytes_q == ADDR_FRAME_BYTES)
                    || (((cmd_q == CMD_CE_A) || (cmd_q == CMD_CE_B))
                        && bytes_q == ONE_BYTE);
  assign start_erase = gate & wen_q & is_erase;
  assign start_prog = gate & wen_q & (cmd_q == CMD_PP)
                      & (bytes_q >= PP_MIN_BYTES);
  assign start_srw = gate & wen_q & (cmd_q == CMD_SRW)
                     & (bytes_q == SRW_FRAME_BYTES);
  assign op_end = busy_q & (op_cnt_q == 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up wait and power-down state

  logic [31:0] pu_cnt_q;

  // Commands before the wait elapses are dropped
  // Restarts on every reset, a mid-run one included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_cnt_q <= 32'h0;
      pu_ready_q <= 1'b0;
    end else if (!pu_ready_q) begin
      if (pu_cnt_q >= PU_CYCLES - 1) begin
        pu_ready_q <= 1'b1;
      end else begin
        pu_cnt_q <= pu_cnt_q + 32'h1;
      end
    end
  end

  // Standby after reset; low power only by command
  // Exit needs only the first whole byte of the identification command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_q <= RST_PD;
    end else if (acc_pd) begin
      pd_q <= 1'b1;
    end else if (acc_exit) begin
      pd_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal operation timer

  op_t op_kind_q;
  logic op_start_q;
  logic op_done_q;

  // Busy lasts exactly the set count of clk cycles, then op_done pulses once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      op_cnt_q <= 32'h0;
      op_kind_q <= OP_IDLE;
      op_start_q <= 1'b0;
      op_done_q <= 1'b0;
    end else begin
      op_start_q <= start_erase | start_prog | start_srw;
      op_done_q <= op_end;
      if (start_erase) begin
        busy_q <= 1'b1;
        op_kind_q <= OP_ERASE;
        op_cnt_q <= ERASE_CYCLES - 1;
      end else if (start_prog) begin
        busy_q <= 1'b1;
        op_kind_q <= OP_PROG;
        op_cnt_q <= PROG_CYCLES - 1;
      end else if (start_srw) begin
        busy_q <= 1'b1;
        op_kind_q <= OP_SRW;
        op_cnt_q <= SRW_CYCLES - 1;
      end else if (op_end) begin
        busy_q <= 1'b0;
        op_kind_q <= OP_IDLE;
      end else if (busy_q) begin
        op_cnt_q <= op_cnt_q - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-enable latch
  // Set cannot meet the self-clear: commands are refused while busy
  // Any self-clear holds the latch low until the next write-enable

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wen_q <= RST_WEN;
    end else if (acc_wren) begin
      wen_q <= 1'b1;
    end else if (acc_wrdi) begin
      wen_q <= 1'b0;
    end else if (op_end) begin
      case (op_kind_q)
        OP_SRW: wen_q <= 1'b0;
        OP_ERASE: wen_q <= 1'b0;
        OP_PROG: wen_q <= 1'b0;
        default: wen_q <= wen_q;
      endcase
    end
  end

  // Status outputs straight from their flops
  assign write_enabled = wen_q;
  assign busy = busy_q;
  assign powered_down = pd_q;
  assign pu_ready = pu_ready_q;
  assign op_start = op_start_q;
  assign op_done = op_done_q;
  assign op_kind = op_kind_q;
endmodule

// ===== verification/flash_host_model.sv
// Host model of the serial link: frames, hold pauses, ID capture.
// Assumes the bench leaves time between frames.
`timescale 1ns/1ps
module flash_host_model (
  output logic sck,
  output logic cs_b,
  output logic si,
  output logic hold_b,
  input wire logic so,
  input wire logic so_oe
);
  logic [15:0] rd_q;
  logic hold_oe_q;
  // Link idles with sck still and chip select high
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    hold_b = 1'b1;
  end
  //////////////////////////////////////////////////////////////////
  // One frame at a 64 ns sck; hold moves only with sck low
  task automatic frame(input logic [7:0] q[$], input int tail, input int hold_at);
    int n;
    n = 8 * q.size() + tail;
    rd_q = 16'h0000;
    hold_oe_q = 1'b0;
    cs_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) begin
        #16 hold_b = 1'b0;
        // Noise on sck and si that the slave must not see
        // Long enough that a clk edge always falls inside the pause
        repeat (8) begin
          #16 sck = ~sck;
          si = ~si;
        end
        hold_oe_q = so_oe;
        #16 hold_b = 1'b1;
      end
      #16 si = (i < 8 * q.size()) ? q[i / 8][7 - i % 8] : 1'b1;
      #16 sck = 1'b1;
      if (so_oe === 1'b1) rd_q = {rd_q[14:0], so};
      #32 sck = 1'b0;
    end
    #32 cs_b = 1'b1;
    // Released line must not keep its last value
    si = ~si;
  endtask
endmodule

// ===== verification/serial_flash_hold_protect_properties.sv
// Port checker of the flash slave, bound to every instance.
// Assumes rst_b low for at least one clk edge at start.
`timescale 1ns/1ps
module serial_flash_hold_protect_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  input wire logic so,
  input wire logic so_oe,
  input wire logic write_enabled,
  input wire logic busy,
  input wire logic powered_down,
  input wire logic pu_ready,
  input wire logic op_start,
  input wire logic op_done,
  input wire flash_pkg::op_t op_kind
);
  import flash_pkg::*;
  //////////////////////////////////////////////////////////////////
  // Two clock domains here, so every property names its own clock
  // Output enable against hold and select
  hold_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    !hold_b |-> !so_oe) else $error("so driven in hold");
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs_b |-> !so_oe) else $error("so driven while deselected");
  // Two falling sck edges inside hold must not move so
  hold_frozen_a: assert property (@(negedge sck) disable iff (!rst_b)
    !hold_b && !$past(hold_b) |-> $stable(so)) else $error("so moved in hold");
  // Operations start only after a whole frame with the latch set
  start_wen_a: assert property (@(posedge clk) disable iff (!rst_b)
    op_start |-> write_enabled && busy) else $error("operation started without latch");
  start_frame_a: assert property (@(posedge clk) disable iff (!rst_b)
    op_start |-> cs_b && pu_ready && !powered_down)
    else $error("operation started inside a frame");
  done_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    op_done |-> !write_enabled) else $error("latch still set after operation");
  op_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    op_start |-> ##[4:25] op_done) else $error("operation never finished");
  kind_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    busy && $past(busy) |-> $stable(op_kind)) else $error("operation kind changed while busy");
  boot_standby_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pu_ready) |-> !powered_down && !write_enabled)
    else $error("not in standby after power-up");
endmodule
bind serial_flash_hold_protect serial_flash_hold_protect_properties chk (.clk(clk),
  .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .so(so), .so_oe(so_oe),
  .write_enabled(write_enabled), .busy(busy), .powered_down(powered_down),
  .pu_ready(pu_ready), .op_start(op_start), .op_done(op_done), .op_kind(op_kind));

// ===== verification/serial_flash_hold_protect_tb_top.sv
// Self-checking bench of the flash slave against a small model.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/1ps
module serial_flash_hold_protect_tb_top;
  import flash_pkg::*;
  // Arbitrary identification value
  localparam logic [7:0] CODE = 8'h5A;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, si, hold_b, so, so_oe, write_enabled, busy, powered_down;
  logic pu_ready, op_start, op_done;
  op_t op_kind, k_start;
  int error_cnt = 0;
  int compares = 0;
  int n_start = 0;
  int n_done = 0;
  int seed = 32'h19DE441C;
  bit wen, pd, rdy;
  logic [7:0] q[$];
  logic [7:0] ers[5] = '{CMD_SSE_A, CMD_SSE_B, CMD_SE, CMD_CE_A, CMD_CE_B};
  always #50 clk = ~clk;
  serial_flash_hold_protect #(.PU_CYCLES(10), .ERASE_CYCLES(20), .PROG_CYCLES(10),
    .SRW_CYCLES(5), .DEVICE_CODE(CODE)) dut (.clk(clk), .rst_b(rst_b), .sck(sck),
    .cs_b(cs_b), .si(si), .hold_b(hold_b), .so(so), .so_oe(so_oe),
    .write_enabled(write_enabled), .busy(busy), .powered_down(powered_down),
    .pu_ready(pu_ready), .op_start(op_start), .op_done(op_done), .op_kind(op_kind));
  flash_host_model host (.sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .so(so),
    .so_oe(so_oe));
  //////////////////////////////////////////////////////////////////
  // Pulses counted off the edge so they are settled
  always @(negedge clk) begin
    if (op_start === 1'b1) begin
      n_start++;
      k_start = op_kind;
    end
    if (op_done === 1'b1) n_done++;
  end
  function automatic logic [7:0] rb();
    return 8'($random(seed));
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  // Model predicts the frame, then the ports are compared
  task automatic send(input string name, input int tail, input int hold_at);
    op_t k;
    int s0, d0;
    k = OP_IDLE;
    s0 = n_start;
    d0 = n_done;
    if (pd) pd = !(q[0] == CMD_ID);
    else if (tail == 0 && rdy) begin
      case (q[0])
        CMD_WREN: if (q.size() == 1) wen = 1;
        CMD_WRDI: if (q.size() == 1) wen = 0;
        CMD_PDOWN: if (q.size() == 1) pd = 1;
        CMD_PP: if (q.size() >= 5 && wen) k = OP_PROG;
        CMD_SRW: if (q.size() == 2 && wen) k = OP_SRW;
        CMD_CE_A, CMD_CE_B: if (q.size() == 1 && wen) k = OP_ERASE;
        CMD_SSE_A, CMD_SSE_B, CMD_SE: if (q.size() == 4 && wen) k = OP_ERASE;
        default: ;
      endcase
    end
    host.frame(q, tail, hold_at);
    repeat (6) @(negedge clk);
    check(8'(n_start - s0), 8'(k != OP_IDLE), "start");
    if (k != OP_IDLE) begin
      check(k_start, k, "kind");
      check(busy, 1'b1, "busy");
      for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
      // One more edge so the done pulse is counted before it is read
      @(negedge clk);
      check(busy, 1'b0, "idle");
      check(8'(n_done - d0), 8'h01, "done");
      wen = 0;
    end
    check(write_enabled, wen, "latch");
    check(powered_down, pd, "power");
    $display("test %s done", name);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    check(powered_down, 1'b0, "standby");
    check(pu_ready, 1'b0, "wait");
    q = '{CMD_WREN};
    send("early", 0, -1);
    for (int i = 0; i < 40 && pu_ready !== 1'b1; i++) @(negedge clk);
    check(pu_ready, 1'b1, "ready");
    rdy = 1;
    send("wren", 0, -1);
    q = '{CMD_WRDI};
    send("wrdi", 0, -1);
    q = '{CMD_PP, rb(), rb(), rb(), rb()};
    send("nolatch", 0, -1);
    q = '{CMD_WREN};
    send("wren", 0, -1);
    q = '{CMD_PP, rb(), rb(), rb(), rb()};
    send("ragged", 3, -1);
    q = '{CMD_CE_A};
    send("offbyte", 5, -1);
    q = '{CMD_SRW, rb(), rb()};
    send("longsrw", 0, -1);
    q = '{CMD_SRW, rb()};
    send("srw", 0, -1);
    foreach (ers[i]) begin
      q = '{CMD_WREN};
      send("wren", 0, -1);
      if (i < 3) q = '{ers[i], rb(), rb(), rb()};
      else q = '{ers[i]};
      send("erase", 0, -1);
    end
    q = '{CMD_WREN};
    send("wren", 0, -1);
    q = '{CMD_PP, rb(), rb(), rb(), rb(), rb()};
    send("program", 0, -1);
    q = '{CMD_ID, rb(), rb(), rb(), 8'h00, 8'h00};
    send("idhold", 0, 36);
    check(host.rd_q[15:8], CODE, "code");
    check(host.rd_q[7:0], CODE, "repeat");
    check(8'(host.hold_oe_q), 8'h00, "holdz");
    q = '{CMD_PDOWN};
    send("pdown", 0, -1);
    q = '{CMD_WREN};
    send("pdwren", 0, -1);
    q = '{CMD_ID};
    send("wake", 0, -1);
    q = '{CMD_WREN};
    send("wren", 0, -1);
    q = '{CMD_PDOWN};
    send("pdown2", 0, -1);
    // Reset in mid-run must land in standby again with the latch clear
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    pd = 0;
    check(powered_down, 1'b0, "reboot");
    check(write_enabled, 1'b0, "relatch");
    check(pu_ready, 1'b0, "rewait");
    $display("test reset done");
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule
